/* dv/nmi_cpu_model.sv */
`timescale 1ns/1ns
// CPU side of the non-maskable handshake; vectored interrupts stay off
module nmi_cpu_model (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        nmiRequest,
  input  wire logic        busEnable,
  input  wire logic [15:0] busId,
  input  wire logic        slow,
  output logic             nmiAck,
  output logic [15:0]      takenId,
  output int               takenCount
);
  int phase;
  int cnt;

  // Aborted fetch, one acknowledge, then a gap so the request can fall
  always @(posedge clock) begin
    if (reset) begin
      nmiAck <= 1'b0;
      takenId <= 16'h0000;
      takenCount <= 0;
      phase <= 0;
      cnt <= 0;
    end else begin
      case (phase)
        0: if (nmiRequest) begin
          phase <= 1;
          cnt <= slow ? 4 : 1;
        end
        1: if (cnt == 1) begin
          phase <= 2;
          cnt <= 0;
          nmiAck <= 1'b1;
        end else begin
          cnt <= cnt - 1;
        end
        // Without the on-board buffer the word comes off the bus anyway
        2: if (busEnable || cnt == 3) begin
          takenId <= busId;
          takenCount <= takenCount + 1;
          nmiAck <= 1'b0;
          phase <= 3;
          cnt <= 0;
        end else begin
          cnt <= cnt + 1;
        end
        default: if (cnt == 4) begin
          phase <= 0;
        end else begin
          cnt <= cnt + 1;
        end
      endcase
    end
  end
endmodule : nmi_cpu_model

/* dv/nmi_source_id_and_priority_chain_tb_top.sv */
`timescale 1ns/1ns
// Bench for the interrupt source identifier and priority chain
module nmi_source_id_and_priority_chain_tb_top;
  typedef struct packed {
    logic        start;
    logic        key;
    logic        pf;
    logic        ecc;
    logic        en;
    logic [15:0] id;
  } row_t;
  localparam int PFAIL = 20;
  logic        clock = 1'b0, reset = 1'b1, slow = 1'b0;
  logic        startButton = 1'b0, keyLocked = 1'b0, powerFailWarn = 1'b0;
  logic        eccDoubleError = 1'b0, externalNmi = 1'b0, eccEnableWrite = 1'b0;
  logic        eccEnableValue = 1'b0, softResetRequest = 1'b0, chainEnableIn = 1'b0;
  logic        nmiAck, nmiRequest, nmiIdentifierEnable, eccNmiEnable;
  logic        systemReset, powerDownWindow;
  logic [10:0] unitBusy = 11'h000, chainEnableOut;
  logic [7:0]  unitArm = 8'h00, unitIntMask;
  logic [15:0] nmiIdentifier, busId, takenId, extBus = 16'hFFFF;
  int          takenCount, takenBase, num_errors = 0, n_tests = 0;
  int          pdwCount = 0, rstCount = 0;
  // Id zero means the edge must be refused
  row_t        rows [5] = '{{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0001},
                            {1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 16'h0000},
                            {1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 16'h0002},
                            {1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 16'h0004},
                            {1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 16'h0000}};

  always #10 clock = ~clock;
  // Bus word: on-board buffer when enabled, else the external source
  assign busId = nmiIdentifierEnable ? nmiIdentifier : extBus;

  nmi_source_id_and_priority_chain #(
    .PFAIL_CYCLES(PFAIL)
  ) nmi_source_id_and_priority_chain_i (
    .clock, .reset, .startButton, .keyLocked, .powerFailWarn,
    .eccDoubleError, .externalNmi, .eccEnableWrite, .eccEnableValue,
    .softResetRequest, .nmiAck, .unitBusy, .unitArm, .chainEnableIn,
    .nmiRequest, .nmiIdentifier, .nmiIdentifierEnable, .eccNmiEnable,
    .systemReset, .powerDownWindow, .chainEnableOut, .unitIntMask
  );

  nmi_cpu_model nmi_cpu_model_i (
    .clock, .reset, .nmiRequest, .busEnable(nmiIdentifierEnable),
    .busId, .slow, .nmiAck, .takenId, .takenCount
  );

  // Lengths of the power-down window and of the made reset
  always @(posedge clock) begin
    if (powerDownWindow === 1'b1)
      pdwCount <= pdwCount + 1;
    if (systemReset === 1'b1)
      rstCount <= rstCount + 1;
  end

  task automatic cmpWord(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmpWord

  task automatic cmpFlag(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmpFlag

  task automatic results();
    if (num_errors == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : results

  task automatic cycles(input int n);
    repeat (n) @(posedge clock);
  endtask : cycles

  // Bounded wait for the CPU model to finish one acknowledge
  task automatic waitTaken(input int was);
    for (int i = 0; i < 40 && takenCount == was; i++)
      @(posedge clock);
    if (takenCount == was) begin
      num_errors++;
      results();
    end
  endtask : waitTaken

  task automatic pinRow(input row_t r);
    int was;
    was = takenCount;
    keyLocked <= r.key;
    eccEnableWrite <= 1'b1;
    eccEnableValue <= r.en;
    cycles(1);
    eccEnableWrite <= 1'b0;
    {startButton, powerFailWarn, eccDoubleError} <= {r.start, r.pf, r.ecc};
    cycles(8);
    {startButton, powerFailWarn, eccDoubleError} <= 3'b000;
    if (r.id === 16'h0000) begin
      cycles(20);
      cmpWord(16'(takenCount - was), 16'h0000);
    end else begin
      waitTaken(was);
      cmpWord(takenId, r.id);
    end
    cycles(8);
  endtask : pinRow

  // Ripple is one link per cycle, so 15 cycles covers all eleven
  task automatic chainStep(input logic [10:0] busy, input logic head,
                           input logic [10:0] exp);
    unitBusy <= busy;
    chainEnableIn <= head;
    cycles(15);
    cmpWord({5'h00, chainEnableOut}, {5'h00, exp});
  endtask : chainStep

  initial begin
    cycles(8);
    reset <= 1'b0;
    cycles(2);
    cmpWord({8'h00, unitIntMask}, 16'h00FF);
    cmpFlag(eccNmiEnable, 1'b0);
    cmpFlag(nmiRequest, 1'b0);
    foreach (rows[k])
      pinRow(rows[k]);
    cmpWord(16'(pdwCount), 16'(PFAIL));
    // Two sources together, slow CPU: manual first, power-fail still held
    slow <= 1'b1;
    {startButton, powerFailWarn} <= 2'b11;
    cycles(8);
    {startButton, powerFailWarn} <= 2'b00;
    takenBase = takenCount;
    waitTaken(takenBase);
    cmpWord(takenId, 16'h0001);
    waitTaken(takenBase + 1);
    cmpWord(takenId, 16'h0002);
    // Off-board source: buffer stays off, word comes from the bus
    cycles(8);
    extBus <= 16'h5A3C;
    externalNmi <= 1'b1;
    takenBase = takenCount;
    waitTaken(takenBase);
    externalNmi <= 1'b0;
    cmpWord(takenId, 16'h5A3C);
    cmpFlag(nmiIdentifierEnable, 1'b0);
    chainStep(11'h000, 1'b1, 11'h7FF);
    chainStep(11'h008, 1'b1, 11'h007);
    chainStep(11'h400, 1'b1, 11'h3FF);
    chainStep(11'h001, 1'b1, 11'h000);
    chainStep(11'h000, 1'b0, 11'h000);
    unitArm <= 8'h20;
    cycles(1);
    unitArm <= 8'h00;
    cycles(2);
    cmpWord({8'h00, unitIntMask}, 16'h00DF);
    // Enable set, then a software reset must clear it again
    eccEnableWrite <= 1'b1;
    eccEnableValue <= 1'b1;
    cycles(1);
    eccEnableWrite <= 1'b0;
    cycles(1);
    cmpFlag(eccNmiEnable, 1'b1);
    softResetRequest <= 1'b1;
    cycles(1);
    softResetRequest <= 1'b0;
    cycles(30);
    cmpWord(16'(rstCount), 16'h0010);
    cmpFlag(eccNmiEnable, 1'b0);
    // Mid-run reset must clear the enable and mask the units again
    eccEnableWrite <= 1'b1;
    eccEnableValue <= 1'b1;
    cycles(1);
    eccEnableWrite <= 1'b0;
    reset <= 1'b1;
    cycles(1);
    reset <= 1'b0;
    cycles(2);
    cmpFlag(eccNmiEnable, 1'b0);
    cmpWord({8'h00, unitIntMask}, 16'h00FF);
    results();
  end
endmodule : nmi_source_id_and_priority_chain_tb_top

/* verilog/nmi_chain_consts.svh */
`ifndef NMI_CHAIN_CONSTS_SVH
`define NMI_CHAIN_CONSTS_SVH

// Clock rate
`define CLOCK_KHZ            50000

// Hold-up time after a power-fail warning, in microseconds
`define PFAIL_WINDOW_US      2000
`define PFAIL_WINDOW_CYCLES  ((`PFAIL_WINDOW_US * `CLOCK_KHZ) / 1000)

// Length of the hardware reset made from a software reset
`define SOFT_RESET_CYCLES    16

// One-hot identifier codes on the three low address/data lines
`define ID_MANUAL            16'h0001
`define ID_POWER_FAIL        16'h0002
`define ID_MEMORY_ERROR      16'h0004

// Bit positions inside the source flag vector
`define SRC_MANUAL           0
`define SRC_POWER_FAIL       1
`define SRC_MEMORY_ERROR     2

// Chain size: on-board links, then off-board links
`define ONBOARD_LINKS        8
`define TOTAL_LINKS          11

`endif

/* verilog/nmi_chain_pkg.sv */
package nmi_chain_pkg;

  // Pending on-board non-maskable sources
  typedef struct packed {
    logic memoryError;
    logic powerFail;
    logic manual;
  } nmi_flags_t;

  // Conditioned front-panel and monitor pins
  typedef struct packed {
    logic startButton;
    logic keyLocked;
    logic powerFailWarn;
    logic eccDoubleError;
  } pin_set_t;

  // Hardware reset generator
  typedef enum logic [0:0] {
    RST_IDLE,
    RST_HOLD
  } reset_state_t;

endpackage : nmi_chain_pkg

/* verilog/nmi_source_id_and_priority_chain.sv */
`timescale 1ns/1ns
`include "nmi_chain_consts.svh"
module nmi_source_id_and_priority_chain #(
  parameter int PFAIL_CYCLES = `PFAIL_WINDOW_CYCLES,
  parameter int LINKS        = `TOTAL_LINKS,
  parameter int ONBOARD      = `ONBOARD_LINKS
) (
  input  wire logic               clock,
  input  wire logic               reset,
  input  wire logic               startButton,
  input  wire logic               keyLocked,
  input  wire logic               powerFailWarn,
  input  wire logic               eccDoubleError,
  input  wire logic               externalNmi,
  input  wire logic               eccEnableWrite,
  input  wire logic               eccEnableValue,
  input  wire logic               softResetRequest,
  input  wire logic               nmiAck,
  input  wire logic [LINKS-1:0]   unitBusy,
  input  wire logic [ONBOARD-1:0] unitArm,
  input  wire logic               chainEnableIn,
  output logic                    nmiRequest,
  output logic [15:0]             nmiIdentifier,
  output logic                    nmiIdentifierEnable,
  output logic                    eccNmiEnable,
  output logic                    systemReset,
  output logic                    powerDownWindow,
  output logic [LINKS-1:0]        chainEnableOut,
  output logic [ONBOARD-1:0]      unitIntMask
);

  nmi_chain_pkg::pin_set_t   pins;
  nmi_chain_pkg::pin_set_t   pinsPrev_q;
  nmi_chain_pkg::nmi_flags_t flags_q;
  nmi_chain_pkg::nmi_flags_t flags_d;
  nmi_chain_pkg::reset_state_t rstState_q;
  nmi_chain_pkg::reset_state_t rstState_d;

  logic        eccEnable_q;
  logic        eccEnable_d;
  logic        nmiRequest_q;
  logic        nmiRequest_d;
  logic [15:0] ident_q;
  logic [15:0] ident_d;
  logic        identEn_q;
  logic        identEn_d;
  logic        ackPrev_q;
  logic [4:0]  rstCount_q;
  logic [4:0]  rstCount_d;
  logic        sysReset_q;
  logic        sysReset_d;
  logic [31:0] pfCount_q;
  logic [31:0] pfCount_d;
  logic        pfWindow_q;
  logic        pfWindow_d;
  logic [LINKS-1:0]   chainIn;
  logic [LINKS-1:0]   chainOut_q;
  logic [LINKS-1:0]   chainOut_d;
  logic [ONBOARD-1:0] mask_q;
  logic [ONBOARD-1:0] mask_d;
  logic        ackEnd;
  logic        anyOnboard;

  // Identifier for the highest pending source; upper bits left zero
  function automatic logic [15:0] pick_ident(input nmi_chain_pkg::nmi_flags_t f);
    if (f.manual)
      return `ID_MANUAL;
    else if (f.powerFail)
      return `ID_POWER_FAIL;
    else if (f.memoryError)
      return `ID_MEMORY_ERROR;
    else
      return 16'h0000;
  endfunction : pick_ident

  // Front-panel and monitor pins come from outside the clock domain
  pin_sync #(
    .WIDTH (4)
  ) u_pins (
    .clock    (clock),
    .reset    (reset),
    .pinIn    ({startButton, keyLocked, powerFailWarn, eccDoubleError}),
    .levelOut (pins)
  );

  assign ackEnd     = ackPrev_q && !nmiAck;
  assign anyOnboard = flags_q.manual || flags_q.powerFail || flags_q.memoryError;

  // Source flags; a new edge in the clearing cycle wins over the clear
  always_comb begin
    flags_d = flags_q;
    if (ackEnd && identEn_q) begin
      if (ident_q == `ID_MANUAL)
        flags_d.manual = 1'b0;
      if (ident_q == `ID_POWER_FAIL)
        flags_d.powerFail = 1'b0;
      if (ident_q == `ID_MEMORY_ERROR)
        flags_d.memoryError = 1'b0;
    end
    if (pins.startButton && !pinsPrev_q.startButton && !pins.keyLocked)
      flags_d.manual = 1'b1;
    if (pins.powerFailWarn && !pinsPrev_q.powerFailWarn)
      flags_d.powerFail = 1'b1;
    if (pins.eccDoubleError && !pinsPrev_q.eccDoubleError && eccEnable_q)
      flags_d.memoryError = 1'b1;
  end

  // Configuration enable; the made system reset clears it like power-up does
  always_comb begin
    eccEnable_d = sysReset_q ? 1'b0 : (eccEnableWrite ? eccEnableValue : eccEnable_q);
  end

  // NMI line and identifier buffer; the CPU aborts its fetch and runs the
  // acknowledge cycle on its own, we only answer that cycle
  always_comb begin
    nmiRequest_d = anyOnboard || externalNmi;
    ident_d      = ident_q;
    identEn_d    = 1'b0;
    if (nmiAck && anyOnboard) begin
      identEn_d = 1'b1;
      if (!identEn_q)
        ident_d = pick_ident(flags_q);
    end else if (!nmiAck) begin
      ident_d = 16'h0000;
    end
  end

  // Software reset stretched into a hardware reset pulse
  always_comb begin
    rstState_d = rstState_q;
    rstCount_d = rstCount_q;
    sysReset_d = 1'b0;
    case (rstState_q)
      nmi_chain_pkg::RST_IDLE: begin
        if (softResetRequest) begin
          rstState_d = nmi_chain_pkg::RST_HOLD;
          rstCount_d = 5'(`SOFT_RESET_CYCLES - 1);
          sysReset_d = 1'b1;
        end
      end
      nmi_chain_pkg::RST_HOLD: begin
        sysReset_d = 1'b1;
        if (rstCount_q == 5'h00)
          rstState_d = nmi_chain_pkg::RST_IDLE;
        else
          rstCount_d = rstCount_q - 5'h01;
        if (rstCount_q == 5'h00)
          sysReset_d = 1'b0;
      end
      default: begin
        rstState_d = nmi_chain_pkg::RST_IDLE;
      end
    endcase
  end

  // Hold-up window after power-fail warning; a new warning edge restarts the long count
  always_comb begin
    pfCount_d  = pfCount_q;
    pfWindow_d = pfWindow_q;
    if (pins.powerFailWarn && !pinsPrev_q.powerFailWarn) begin
      pfCount_d  = 32'(PFAIL_CYCLES - 1);
      pfWindow_d = 1'b1;
    end else if (pfWindow_q) begin
      if (pfCount_q == 32'h0000_0000)
        pfWindow_d = 1'b0;
      else
        pfCount_d = pfCount_q - 32'h0000_0001;
    end
  end

  // Daisy chain, link 0 highest priority; off-board links rank last
  assign chainIn[0] = chainEnableIn;
  genvar g;
  generate
    for (g = 1; g < LINKS; g++) begin : g_link
      assign chainIn[g] = chainOut_q[g-1];
    end
  endgenerate

  // Registered link outputs; a busy link drops enable to all below it
  always_comb begin
    for (int i = 0; i < LINKS; i++) begin
      chainOut_d[i] = chainIn[i] && !unitBusy[i];
    end
  end

  // Peripherals come up masked until their vector is loaded
  always_comb begin
    mask_d = mask_q & ~unitArm;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      flags_q      <= '0;
      pinsPrev_q   <= '0;
      eccEnable_q  <= 1'b0;
      nmiRequest_q <= 1'b0;
      ident_q      <= 16'h0000;
      identEn_q    <= 1'b0;
      ackPrev_q    <= 1'b0;
      rstState_q   <= nmi_chain_pkg::RST_IDLE;
      rstCount_q   <= 5'h00;
      sysReset_q   <= 1'b0;
      pfCount_q    <= 32'h0000_0000;
      pfWindow_q   <= 1'b0;
      chainOut_q   <= '0;
      mask_q       <= '1;
    end else begin
      flags_q      <= flags_d;
      pinsPrev_q   <= pins;
      eccEnable_q  <= eccEnable_d;
      nmiRequest_q <= nmiRequest_d;
      ident_q      <= ident_d;
      identEn_q    <= identEn_d;
      ackPrev_q    <= nmiAck;
      rstState_q   <= rstState_d;
      rstCount_q   <= rstCount_d;
      sysReset_q   <= sysReset_d;
      pfCount_q    <= pfCount_d;
      pfWindow_q   <= pfWindow_d;
      chainOut_q   <= chainOut_d;
      mask_q       <= mask_d;
    end
  end

  // Identifier is a service-routine pointer; passed as captured
  assign nmiIdentifier       = ident_q;
  assign nmiIdentifierEnable = identEn_q;
  assign nmiRequest          = nmiRequest_q;
  assign eccNmiEnable        = eccEnable_q;
  assign systemReset         = sysReset_q;
  assign powerDownWindow     = pfWindow_q;
  assign chainEnableOut      = chainOut_q;
  assign unitIntMask         = mask_q;

  // Checks
  sequence s_pf_edge;
    pins.powerFailWarn && !pinsPrev_q.powerFailWarn;
  endsequence

  sequence s_ack_onboard;
    nmiAck && anyOnboard;
  endsequence

  property p_pf_raises;
    @(posedge clock) disable iff (reset)
    s_pf_edge |=> flags_q.powerFail ##1 nmiRequest;
  endproperty
  a_pf_raises: assert property (p_pf_raises)
    else $error("power-fail edge did not raise NMI");

  property p_soft_reset;
    @(posedge clock) disable iff (reset)
    (softResetRequest && rstState_q == nmi_chain_pkg::RST_IDLE) |=> systemReset [*8];
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("software reset not stretched");

  property p_ecc_gate;
    @(posedge clock) disable iff (reset)
    $rose(flags_q.memoryError) |-> $past(eccEnable_q) && $past(pins.eccDoubleError);
  endproperty
  a_ecc_gate: assert property (p_ecc_gate)
    else $error("memory NMI without enable and error");

  property p_ecc_reset;
    @(posedge clock) (reset || systemReset) |=> !eccNmiEnable;
  endproperty
  a_ecc_reset: assert property (p_ecc_reset)
    else $error("enable bit survived reset");

  property p_ident_onehot;
    @(posedge clock) disable iff (reset)
    nmiIdentifierEnable |-> $onehot(nmiIdentifier[3:0]) && nmiIdentifier[3] == 1'b0;
  endproperty
  a_ident_onehot: assert property (p_ident_onehot)
    else $error("identifier not one-hot");

  property p_buffer_window;
    @(posedge clock) disable iff (reset)
    s_ack_onboard |=> nmiIdentifierEnable;
  endproperty
  a_buffer_window: assert property (p_buffer_window)
    else $error("identifier buffer missed acknowledge");

  property p_ext_off;
    @(posedge clock) disable iff (reset)
    (nmiAck && !anyOnboard) |=> !nmiIdentifierEnable;
  endproperty
  a_ext_off: assert property (p_ext_off)
    else $error("buffer on for external NMI");

  property p_block_lower;
    @(posedge clock) disable iff (reset)
    unitBusy[0] |=> !chainEnableOut[0] ##1 !chainEnableOut[1];
  endproperty
  a_block_lower: assert property (p_block_lower)
    else $error("busy link did not block lower links");

  property p_locked;
    @(posedge clock) disable iff (reset)
    ($rose(flags_q.manual)) |-> !$past(pins.keyLocked);
  endproperty
  a_locked: assert property (p_locked)
    else $error("manual NMI while locked");

  property p_hold_flag;
    @(posedge clock) disable iff (reset)
    (flags_q.powerFail && !ackEnd) |=> flags_q.powerFail;
  endproperty
  a_hold_flag: assert property (p_hold_flag)
    else $error("flag dropped before read");

endmodule : nmi_source_id_and_priority_chain

/* verilog/pin_sync.sv */
`timescale 1ns/1ns
// Three-stage synchroniser; output only moves once stages two and three agree
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] levelOut
);

  logic [WIDTH-1:0] stage1_q;
  logic [WIDTH-1:0] stage2_q;
  logic [WIDTH-1:0] stage3_q;
  logic [WIDTH-1:0] level_q;
  logic [WIDTH-1:0] level_d;

  // Filter: stage1 is read by stage2 only
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      level_d[i] = (stage2_q[i] == stage3_q[i]) ? stage3_q[i] : level_q[i];
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      stage1_q <= '0;
      stage2_q <= '0;
      stage3_q <= '0;
      level_q  <= '0;
    end else begin
      stage1_q <= pinIn;
      stage2_q <= stage1_q;
      stage3_q <= stage2_q;
      level_q  <= level_d;
    end
  end

  assign levelOut = level_q;

endmodule : pin_sync
